//--- fpc_pkg.sv
package fpc_pkg;
   // Panel geometry
   localparam int ROWS = 1536;
   localparam int COLS = 2048;
   localparam int GROUP_COLS = 128;
   // Word widths
   localparam int RAW_W = 14;
   localparam int OUT_W = 16;
   localparam int ACC_W = 24;
   // Reference averaging
   localparam int MAX_AVG = 1024;
   localparam int AVG_W = 11;
   // Scaling factor before the first flat calibration
   localparam logic [15:0] MEDIAN_RESET = 16'h2000;
   // Central region used for the scaling factor: 512 rows by 1024 columns
   localparam int CTR_ROW_LO = 512;
   localparam int CTR_ROW_HI = 1024;
   localparam int CTR_COL_LO = 512;
   localparam int CTR_COL_HI = 1536;
   localparam int CTR_SHIFT = 19;
   typedef enum logic [1:0] {MODE_CORRECT, MODE_DARK_AVG, MODE_FLAT_AVG} mode_t;
endpackage : fpc_pkg

//--- seq_divider.sv
module seq_divider #(
   parameter int N = 30,
   parameter int M = 14
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Request
   input wire logic start,
   input wire logic [N-1:0] dividend,
   input wire logic [M-1:0] divisor,
   // Answer
   output logic [N-1:0] quotient,
   output logic done
);
   localparam int CNT_W = $clog2(N + 1);
   logic [M-1:0] rem_r;
   logic [N-1:0] quo_r;
   logic [CNT_W-1:0] cnt_r;
   logic done_r;
   wire [M:0] shifted = {rem_r, quo_r[N-1]};
   wire ge = shifted >= {1'b0, divisor};
   wire [M:0] diff = shifted - {1'b0, divisor};

   // Restoring divide, one quotient bit per clock; divisor zero is never requested
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         rem_r <= '0;
         quo_r <= '0;
         cnt_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= start ? 1'b0 : (cnt_r == CNT_W'(1));
         if (start)
         begin
            rem_r <= '0;
            quo_r <= dividend;
            cnt_r <= CNT_W'(N);
         end
         else if (cnt_r != '0)
         begin
            rem_r <= ge ? diff[M-1:0] : shifted[M-1:0];
            quo_r <= {quo_r[N-2:0], ge};
            cnt_r <= cnt_r - CNT_W'(1);
         end
      end
   end

   assign quotient = quo_r;
   assign done = done_r;
endmodule : seq_divider

//--- flat_panel_pixel_correction.sv
// Overview of operation
// RQ1: Frames are 1,536 rows by 2,048 columns and corrected at full resolution.
// RQ2: Upper and lower halves are scanned together, one row active in each half, row by row.
// RQ3: Exactly one row per half is selected for readout at any time.
// RQ4: Each group of 128 columns is presented one column after another on one stream.
// RQ5: Every raw sample taken in is a 14-bit value.
// RQ6: Corrected pixel is (raw minus dark) over (flat minus dark), times the flat median; the code multiplies by the mean of the centre region instead.
// RQ7: The dark reference is averaged from frames taken with the panel unlit.
// RQ8: The scaling factor comes from the dark-subtracted centre of the flat reference.
// RQ9: Dark and flat references are averages over a programmable count up to 1,024 frames.
// RQ10: A pixel flagged defective is replaced by an estimate from its nearest neighbours.
// RQ11: A pixel whose flat equals its dark is treated as defective, never divided by zero.
// RQ12: Results saturate to the output word instead of wrapping.
module flat_panel_pixel_correction #(
   parameter int ROWS = fpc_pkg::ROWS,
   parameter int COLS = fpc_pkg::COLS,
   parameter int GROUP_COLS = fpc_pkg::GROUP_COLS,
   parameter int RAW_W = fpc_pkg::RAW_W,
   parameter int OUT_W = fpc_pkg::OUT_W,
   parameter int ACC_W = fpc_pkg::ACC_W,
   parameter int AVG_W = fpc_pkg::AVG_W
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Operating mode
   input wire fpc_pkg::mode_t mode,
   input wire logic [AVG_W-1:0] avg_frames,
   input wire logic [AVG_W-1:0] frame_index,
   // Scan control toward the panel
   output logic row_gate_r,
   output logic [$clog2(ROWS)-1:0] row_upper_r,
   output logic [$clog2(ROWS)-1:0] row_lower_r,
   output logic [$clog2(COLS/GROUP_COLS)-1:0] group_sel_r,
   output logic [$clog2(GROUP_COLS)-1:0] chan_sel_r,
   output logic frame_end_r,
   output logic in_ready_r,
   // Raw samples from the panel pins
   input wire logic [RAW_W-1:0] raw_upper,
   input wire logic [RAW_W-1:0] raw_lower,
   input wire logic raw_strobe,
   // Reference data for the scan address
   input wire logic [RAW_W-1:0] dark_upper,
   input wire logic [RAW_W-1:0] dark_lower,
   input wire logic [RAW_W-1:0] flat_upper,
   input wire logic [RAW_W-1:0] flat_lower,
   input wire logic defect_upper,
   input wire logic defect_lower,
   input wire logic [ACC_W-1:0] acc_upper,
   input wire logic [ACC_W-1:0] acc_lower,
   // Corrected output
   output logic pix_valid_r,
   output logic pix_half_r,
   output logic [OUT_W-1:0] pix_r,
   output logic [ACC_W-1:0] acc_r,
   output logic [OUT_W-1:0] median_r
);
   localparam int HALF = ROWS / 2;
   localparam int RW = $clog2(ROWS);
   localparam int CW = $clog2(COLS);
   localparam int CHW = $clog2(GROUP_COLS);
   localparam int DIV_N = RAW_W + OUT_W;
   localparam int MSW = OUT_W + fpc_pkg::CTR_SHIFT + 1;

   if (ROWS % 2 != 0 || COLS % GROUP_COLS != 0 || (1 << CHW) != GROUP_COLS ||
       OUT_W < RAW_W || AVG_W > RAW_W || ACC_W > DIV_N || (1 << (AVG_W - 1)) <
       fpc_pkg::MAX_AVG)
   begin : bad_params
      $error("flat_panel_pixel_correction: unsupported parameters");
   end

   typedef enum {S_IDLE, S_CALC, S_DIV, S_OUT} state_t;
   state_t state_r, state_nxt;

   // Pin synchronisers; the strobe edge is taken only from the second stage
   logic [RAW_W-1:0] up_s1, up_s2, lo_s1, lo_s2;
   logic stb_s1, stb_s2, stb_d;
   always_ff @(posedge clock)
   begin
      up_s1 <= raw_upper;
      up_s2 <= up_s1;
      lo_s1 <= raw_lower;
      lo_s2 <= lo_s1;
      stb_s1 <= srst ? 1'b0 : raw_strobe;
      stb_s2 <= srst ? 1'b0 : stb_s1;
      stb_d <= srst ? 1'b0 : stb_s2;
   end
   // A strobe while busy is not taken: the panel must wait for in_ready_r
   wire take = stb_s2 & ~stb_d & in_ready_r;

   // Latched pair, index 0 upper half, 1 lower half
   logic [RAW_W-1:0] raw_l [2];
   logic [RAW_W-1:0] dark_l [2];
   logic [RAW_W-1:0] flat_l [2];
   logic defect_l [2];
   logic [ACC_W-1:0] acc_l [2];
   logic half_r;
   logic [RW-1:0] row_r;
   logic [CW-1:0] col_r;
   logic [OUT_W-1:0] res_r;
   logic [OUT_W-1:0] left_r [2];
   logic [OUT_W-1:0] lb_mem [2*COLS];
   logic [MSW-1:0] med_sum_r;

   // Current sample
   wire [RAW_W-1:0] raw_c = raw_l[half_r];
   wire [RAW_W-1:0] dark_c = dark_l[half_r];
   wire [RAW_W-1:0] flat_c = flat_l[half_r];
   wire [RAW_W-1:0] num_c = (raw_c > dark_c) ? raw_c - dark_c : '0; // [RQ6] [RQ12]
   wire [RAW_W-1:0] den_c = (flat_c > dark_c) ? flat_c - dark_c : '0; // [RQ6]
   wire bad_c = defect_l[half_r] | (den_c == '0); // [RQ11]
   wire is_avg = mode != fpc_pkg::MODE_CORRECT;
   wire [AVG_W-1:0] avg_eff = (avg_frames == '0) ? AVG_W'(1) : avg_frames;
   wire first_c = frame_index == '0;
   wire last_c = frame_index == avg_eff - AVG_W'(1);
   // Accumulate raw frames, then divide the total by the frame count [RQ9] [RQ7]
   wire [ACC_W-1:0] sum_c = (first_c ? '0 : acc_l[half_r]) + ACC_W'(raw_c);
   wire need_div = is_avg ? last_c : ~bad_c;
   wire [DIV_N-1:0] dividend = is_avg ? DIV_N'(sum_c) : DIV_N'(num_c) * DIV_N'(median_r);
   wire [RAW_W-1:0] divisor = is_avg ? RAW_W'(avg_eff) : den_c;
   wire [DIV_N-1:0] quo;
   wire div_done;
   wire div_start = state_r == S_CALC && need_div;

   // Neighbour estimate from the left pixel and the pixel above in the same half
   wire left_ok = col_r != '0;
   wire above_ok = row_r != '0;
   wire [OUT_W-1:0] above_c = lb_mem[{half_r, col_r}];
   wire [OUT_W:0] pair_sum = {1'b0, left_r[half_r]} + {1'b0, above_c};
   wire [OUT_W-1:0] est_c = (left_ok && above_ok) ? pair_sum[OUT_W:1] :
                            left_ok ? left_r[half_r] : above_ok ? above_c : '0; // [RQ10]
   wire [OUT_W-1:0] sum_sat = (|(sum_c >> OUT_W)) ? '1 : sum_c[OUT_W-1:0]; // [RQ12]
   wire [OUT_W-1:0] quo_sat = (|quo[DIV_N-1:OUT_W]) ? '1 : quo[OUT_W-1:0]; // [RQ12]
   wire [OUT_W-1:0] direct_c = is_avg ? sum_sat : est_c; // [RQ10]

   // Scan position
   wire adv = state_r == S_OUT && half_r;
   wire last_col = col_r == CW'(COLS - 1);
   wire last_row = row_r == RW'(HALF - 1);
   wire frame_wrap = adv && last_col && last_row;

   // Centre of the flat reference, dark subtracted [RQ8]
   wire [RW-1:0] frow = half_r ? row_r + RW'(HALF) : row_r;
   wire in_ctr = frow >= RW'(fpc_pkg::CTR_ROW_LO) && frow < RW'(fpc_pkg::CTR_ROW_HI) &&
                 col_r >= CW'(fpc_pkg::CTR_COL_LO) && col_r < CW'(fpc_pkg::CTR_COL_HI);
   wire flat_final = mode == fpc_pkg::MODE_FLAT_AVG && last_c;
   wire [OUT_W-1:0] flat_net = (res_r > OUT_W'(dark_c)) ? res_r - OUT_W'(dark_c) : '0;
   wire [MSW-1:0] med_add = (state_r == S_OUT && flat_final && in_ctr) ? MSW'(flat_net) : '0;
   wire [MSW-1:0] med_total = med_sum_r + med_add;
   wire [MSW-1:0] med_avg = med_total >> fpc_pkg::CTR_SHIFT;
   wire [OUT_W-1:0] med_new = (|(med_avg >> OUT_W)) ? '1 : med_avg[OUT_W-1:0];

   seq_divider #(.N(DIV_N), .M(RAW_W)) u_div (
      .clock(clock),
      .srst(srst),
      .start(div_start),
      .dividend(dividend),
      .divisor(divisor),
      .quotient(quo),
      .done(div_done)
   );

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: state_nxt = take ? S_CALC : S_IDLE;
         S_CALC: state_nxt = need_div ? S_DIV : S_OUT; // [RQ11]
         S_DIV: state_nxt = div_done ? S_OUT : S_DIV;
         S_OUT: state_nxt = half_r ? S_IDLE : S_CALC; // [RQ2]
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (take)
      begin
         raw_l[0] <= up_s2; // [RQ5]
         raw_l[1] <= lo_s2; // [RQ5]
         dark_l[0] <= dark_upper;
         dark_l[1] <= dark_lower;
         flat_l[0] <= flat_upper;
         flat_l[1] <= flat_lower;
         defect_l[0] <= defect_upper;
         defect_l[1] <= defect_lower;
         acc_l[0] <= acc_upper;
         acc_l[1] <= acc_lower;
      end
      if (state_r == S_CALC)
         acc_r <= sum_c;
      if (state_r == S_OUT)
         lb_mem[{half_r, col_r}] <= res_r;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_r <= S_IDLE;
         half_r <= 1'b0;
         row_r <= '0;
         col_r <= '0;
         res_r <= '0;
         left_r[0] <= '0;
         left_r[1] <= '0;
         med_sum_r <= '0;
         median_r <= fpc_pkg::MEDIAN_RESET;
         in_ready_r <= 1'b0;
         row_gate_r <= 1'b0;
         row_upper_r <= '0;
         row_lower_r <= RW'(HALF);
         frame_end_r <= 1'b0;
         pix_valid_r <= 1'b0;
         pix_half_r <= 1'b0;
         pix_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         in_ready_r <= state_nxt == S_IDLE;
         row_gate_r <= 1'b1; // [RQ3]
         frame_end_r <= frame_wrap;
         pix_valid_r <= state_r == S_OUT;
         pix_half_r <= half_r;
         pix_r <= res_r;
         if (state_r == S_CALC && !need_div)
            res_r <= direct_c;
         else if (state_r == S_DIV && div_done)
            res_r <= is_avg ? quo_sat : quo_sat; // [RQ6] [RQ9]
         if (state_r == S_OUT)
         begin
            left_r[half_r] <= res_r;
            half_r <= ~half_r;
            med_sum_r <= frame_wrap ? '0 : med_total;
         end
         if (frame_wrap && flat_final)
            median_r <= med_new; // [RQ8]
         if (adv)
         begin
            col_r <= last_col ? '0 : col_r + CW'(1); // [RQ4]
            if (last_col)
            begin
               row_r <= last_row ? '0 : row_r + RW'(1); // [RQ1] [RQ2]
               row_upper_r <= last_row ? '0 : row_r + RW'(1); // [RQ3]
               row_lower_r <= last_row ? RW'(HALF) : row_r + RW'(HALF + 1); // [RQ2]
            end
         end
      end
   end

   assign group_sel_r = col_r[CW-1:CHW]; // [RQ4]
   assign chan_sel_r = col_r[CHW-1:0]; // [RQ4]

   // Done rises on the same edge that shifts in the last quotient bit
   localparam int DIV_LO = DIV_N + 1;
   sequence s_upper_out;
      pix_valid_r && !pix_half_r;
   endsequence
   sequence s_lower_out;
      pix_valid_r && pix_half_r;
   endsequence

   AST_HALVES_TOGETHER: assert property (@(posedge clock) disable iff (srst) // [RQ2]
      row_lower_r == row_upper_r + RW'(HALF)) else $error("halves not scanned together");
   AST_ROW_RANGE: assert property (@(posedge clock) disable iff (srst) // [RQ1]
      row_upper_r < RW'(HALF) && row_r == row_upper_r) else $error("row out of range");
   AST_ONE_ROW_GATED: assert property (@(posedge clock) disable iff (srst) // [RQ3]
      $changed(row_upper_r) |-> $past(adv) && $past(last_col)) else $error("row moved early");
   AST_COLUMN_STEP: assert property (@(posedge clock) disable iff (srst) // [RQ4]
      adv && !last_col |=> chan_sel_r == $past(chan_sel_r) + CHW'(1) ||
      chan_sel_r == '0) else $error("column order broken");
   AST_PAIR_ORDER: assert property (@(posedge clock) disable iff (srst) // [RQ2]
      s_upper_out |-> ##[1:40] s_lower_out) else $error("lower half result missing");
   AST_NO_ZERO_DIV: assert property (@(posedge clock) disable iff (srst) // [RQ11]
      state_r == S_CALC && !is_avg && den_c == '0 |=> state_r == S_OUT)
      else $error("divide by zero attempted");
   AST_DEFECT_EST: assert property (@(posedge clock) disable iff (srst) // [RQ10]
      state_r == S_CALC && !is_avg && bad_c |=> res_r == $past(est_c) ##1 pix_r == $past(res_r))
      else $error("defect not replaced");
   AST_DIV_TIME: assert property (@(posedge clock) disable iff (srst) // [RQ6]
      div_start |-> ##[DIV_LO:DIV_LO] div_done ##2 pix_valid_r) else $error("divide late");
   AST_SATURATE: assert property (@(posedge clock) disable iff (srst) // [RQ12]
      state_r == S_DIV && div_done && (|quo[DIV_N-1:OUT_W]) |=> res_r == '1)
      else $error("result wrapped");
   AST_READY_IDLE: assert property (@(posedge clock) disable iff (srst) // [RQ9]
      in_ready_r |-> state_r == S_IDLE) else $error("ready while busy");
endmodule : flat_panel_pixel_correction

//--- panel_model.sv
module panel_model (
   // Clock and scan handshake
   input wire logic clock,
   input wire logic in_ready_r,
   // Sample pins
   output logic [fpc_pkg::RAW_W-1:0] raw_upper,
   output logic [fpc_pkg::RAW_W-1:0] raw_lower,
   output logic raw_strobe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      raw_upper = 14'h0000;
      raw_lower = 14'h0000;
      raw_strobe = 1'b0;
   end

   // Offer one pair, hold it past the take, then release the pins
   task automatic offer(input logic [fpc_pkg::RAW_W-1:0] u, input logic [fpc_pkg::RAW_W-1:0] l);
      int n;
      n = 0;
      while (in_ready_r !== 1'b1 && n < 200)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      raw_upper = u;
      raw_lower = l;
      raw_strobe = 1'b1;
      n = 0;
      while (in_ready_r !== 1'b0 && n < 200)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      @(posedge clock);
      #1;
      // Released lines show the inverse so a late sample cannot pass by luck
      raw_strobe = 1'b0;
      raw_upper = ~u;
      raw_lower = ~l;
      // Strobe stays low long enough for the synchroniser to see the next rise
      repeat (2) @(posedge clock);
      #1;
   endtask : offer
endmodule : panel_model

//--- flat_panel_pixel_correction_bench.sv
module flat_panel_pixel_correction_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // Small panel keeps whole frames affordable
   localparam int ROWS_T = 4;
   localparam int COLS_T = 256;
   localparam int RU = 32'h0000_0064;
   localparam int RL = 32'h0000_00c8;
   logic clock, srst, row_gate_r, frame_end_r, in_ready_r, raw_strobe, pix_valid_r, pix_half_r;
   logic defect_upper, defect_lower;
   logic [1:0] row_upper_r, row_lower_r;
   logic [0:0] group_sel_r;
   logic [6:0] chan_sel_r;
   logic [10:0] avg_frames, frame_index;
   logic [13:0] raw_upper, raw_lower, dark_upper, dark_lower, flat_upper, flat_lower;
   logic [23:0] acc_upper, acc_lower, acc_r;
   logic [15:0] pix_r, median_r, left_u, left_l;
   fpc_pkg::mode_t mode;
   int bad_count, check_count, cycles, fe_count, col, row, frames;

   flat_panel_pixel_correction #(.ROWS(ROWS_T), .COLS(COLS_T)) uut (
      .clock, .srst, .mode, .avg_frames, .frame_index, .row_gate_r, .row_upper_r, .row_lower_r,
      .group_sel_r, .chan_sel_r, .frame_end_r, .in_ready_r, .raw_upper, .raw_lower, .raw_strobe,
      .dark_upper, .dark_lower, .flat_upper, .flat_lower, .defect_upper, .defect_lower,
      .acc_upper, .acc_lower, .pix_valid_r, .pix_half_r, .pix_r, .acc_r, .median_r);
   panel_model panel (.clock, .in_ready_r, .raw_upper, .raw_lower, .raw_strobe);

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // Two divided frames cost about 72 cycles a pair; the run needs roughly 84k cycles
   always @(posedge clock)
   begin
      cycles++;
      if (frame_end_r === 1'b1) fe_count++;
      if (cycles == 95000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic wait_valid;
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         #1;
         n++;
      end
      while (pix_valid_r !== 1'b1 && n < 100);
      if (n >= 100) check(32'h0000_0000, 32'h0000_0001);
   endtask : wait_valid

   function automatic logic [15:0] exp_pix(input logic [13:0] r, d, f, input logic def,
         input logic [15:0] left);
      logic [31:0] q;
      if (def || f <= d) return left;
      if (r < d) return 16'h0000;
      q = 32'(r - d) * 32'(fpc_pkg::MEDIAN_RESET) / 32'(f - d);
      return (q > 32'h0000_ffff) ? 16'hffff : q[15:0];
   endfunction : exp_pix

   task automatic send_pair(input logic [13:0] ru, rl, du, dl, fu, fl, input logic dfu, dfl,
         input logic [23:0] au, al, output logic [15:0] pu, pl, output logic [23:0] cu, cl);
      {dark_upper, dark_lower, flat_upper, flat_lower} = {du, dl, fu, fl};
      {defect_upper, defect_lower, acc_upper, acc_lower} = {dfu, dfl, au, al};
      fork
         panel.offer(ru, rl);
         begin
            wait_valid();
            check(32'(pix_half_r), 32'h0000_0000);
            pu = pix_r;
            cu = acc_r;
            wait_valid();
            check(32'(pix_half_r), 32'h0000_0001);
            pl = pix_r;
            cl = acc_r;
         end
      join
      col = (col + 1) % COLS_T;
      if (col == 0) row = (row + 1) % (ROWS_T / 2);
      if (col == 0 && row == 0) frames++;
      repeat (3) @(posedge clock);
      #1;
      check(32'(chan_sel_r), col % fpc_pkg::GROUP_COLS);
      check(32'(group_sel_r), col / fpc_pkg::GROUP_COLS);
      check(32'(row_upper_r), row);
      check(32'(row_lower_r), row + ROWS_T / 2);
      check(fe_count, frames);
   endtask : send_pair

   task automatic corr(input logic [13:0] ru, rl, du, dl, fu, fl, input logic dfu, dfl);
      logic [15:0] pu, pl;
      logic [23:0] cu, cl;
      send_pair(ru, rl, du, dl, fu, fl, dfu, dfl, 24'h00_0000, 24'h00_0000, pu, pl, cu, cl);
      left_u = exp_pix(ru, du, fu, dfu, left_u);
      left_l = exp_pix(rl, dl, fl, dfl, left_l);
      check(32'(pu), 32'(left_u));
      check(32'(pl), 32'(left_l));
   endtask : corr

   task automatic t_reset;
      srst = 1'b1;
      repeat (12) @(posedge clock);
      #1;
      check(32'(in_ready_r), 32'h0000_0000);
      check(32'(pix_valid_r), 32'h0000_0000);
      check(32'(row_lower_r), ROWS_T / 2);
      check(32'(median_r), 32'h0000_2000);
      srst = 1'b0;
      @(posedge clock);
      #1;
      check(32'(row_gate_r), 32'h0000_0001);
      check(32'(in_ready_r), 32'h0000_0001);
      $display("reset test done");
   endtask : t_reset

   task automatic t_correct;
      // Exact ratio, defect, saturation with underflow, flat not above dark, full scale
      corr(14'h1100, 14'h0900, 14'h0100, 14'h0100, 14'h0900, 14'h0900, 1'b0, 1'b0);
      corr(14'h3fff, 14'h3fff, 14'h0100, 14'h0100, 14'h0900, 14'h0900, 1'b1, 1'b1);
      corr(14'h0200, 14'h0050, 14'h0100, 14'h0100, 14'h0101, 14'h0900, 1'b0, 1'b0);
      corr(14'h0800, 14'h0800, 14'h0200, 14'h0300, 14'h0200, 14'h0100, 1'b0, 1'b0);
      corr(14'h3fff, 14'h3fff, 14'h0000, 14'h0000, 14'h3fff, 14'h1fff, 1'b0, 1'b0);
      $display("correction test done");
   endtask : t_correct

   task automatic run_frame(input fpc_pkg::mode_t m, input int navg, idx, input logic [1:0] chk,
         input logic dfct);
      logic [15:0] pu, pl;
      logic [23:0] cu, cl, au, al;
      mode = m;
      avg_frames = 11'(navg);
      frame_index = 11'(idx);
      // The first frame of an average must ignore whatever the store holds
      au = (idx == 0) ? 24'hab_cdef : 24'(idx * RU);
      al = (idx == 0) ? 24'hab_cdef : 24'(idx * RL);
      do
      begin
         send_pair(14'(RU), 14'(RL), 14'h0010, 14'h0010, 14'h0800, 14'h0800, dfct, dfct, au, al,
            pu, pl, cu, cl);
         if (chk[0]) check(32'(cu), (idx + 1) * RU);
         if (chk[0]) check(32'(cl), (idx + 1) * RL);
         if (chk[1]) check(32'(pu), (idx + 1) * RU / navg);
         if (chk[1]) check(32'(pl), (idx + 1) * RL / navg);
      end
      while (col != 0 || row != 0);
      $display("frame test done: mode %0d index %0d", m, idx);
   endtask : run_frame

   initial
   begin
      srst = 1'b1;
      mode = fpc_pkg::MODE_CORRECT;
      avg_frames = 11'h001;
      frame_index = 11'h000;
      {dark_upper, dark_lower, flat_upper, flat_lower} = 56'h0;
      {defect_upper, defect_lower, acc_upper, acc_lower} = 50'h0;
      left_u = 16'h0000;
      left_l = 16'h0000;
      t_reset();
      t_correct();
      run_frame(fpc_pkg::MODE_CORRECT, 1, 0, 2'b00, 1'b1);
      run_frame(fpc_pkg::MODE_DARK_AVG, 2, 0, 2'b01, 1'b0);
      run_frame(fpc_pkg::MODE_DARK_AVG, 2, 1, 2'b11, 1'b0);
      run_frame(fpc_pkg::MODE_FLAT_AVG, 1, 0, 2'b11, 1'b0);
      end_of_test();
   end
endmodule : flat_panel_pixel_correction_bench
